// ===== hdl/dic_channel.sv
`include "dic_consts.svh"

module dic_channel import dic_pkg::*; (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic tick_in,
   input wire dic_volt_t volt_in,
   input wire dic_volt_t act_thr_in,
   input wire dic_volt_t rel_thr_in,
   input wire logic normally_closed_in,
   input wire logic ac_mode_in,
   input wire dic_dly_t act_dly_in,
   input wire dic_dly_t drop_dly_in,
   input wire logic clear_in,
   output logic state_out,
   output dic_cnt_t count_out
);
   typedef struct packed {
      logic energized;
      logic qual;
      dic_dly_t timer;
      dic_cnt_t count;
   } dic_ch_st_t;

   dic_ch_st_t st_ff;
   dic_ch_st_t nxt_st;
   dic_volt_t rel_eff;
   dic_dly_t dly;
   logic raw;

   always_comb begin
      nxt_st = st_ff;
      rel_eff = ac_mode_in ? dic_volt_t'(act_thr_in / `DIC_AC_DIVISOR)
                           : rel_thr_in; // see RULE9
      raw = st_ff.energized ^ normally_closed_in; // see RULE4
      dly = st_ff.qual ? drop_dly_in + (ac_mode_in ? 22'(`DIC_AC_EXTRA_MS)
                                                   : 22'h0) // see RULE9
                       : act_dly_in;
      if (clear_in) begin
         nxt_st.count = '0; // see RULE11
      end
      if (tick_in) begin
         // inside the band the old level holds
         if (volt_in > act_thr_in) begin
            nxt_st.energized = 1'b1; // see RULE5
         end else if (volt_in < rel_eff) begin
            nxt_st.energized = 1'b0; // see RULE6
         end // see RULE13
         // judge the level just sampled so the change shows at this tick
         raw = nxt_st.energized ^ normally_closed_in; // see RULE1 RULE4
         // any bounce back restarts the wait
         if (raw == st_ff.qual) begin
            nxt_st.timer = '0; // see RULE14
         end else if (st_ff.timer >= dly) begin
            nxt_st.qual = raw; // see RULE7 RULE8 RULE1
            nxt_st.timer = '0;
            if (raw) begin
               // an event in the clearing cycle still counts
               nxt_st.count = nxt_st.count + 32'h1; // see RULE10
            end
         end else begin
            nxt_st.timer = st_ff.timer + 22'(`DIC_SCAN_MS); // see RULE14
         end
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign state_out = st_ff.qual;
   assign count_out = st_ff.count;
endmodule

// ===== hdl/dic_consts.svh
// Notes on behaviour
// RULE1: every channel is sampled and its state updated once per 5 ms scan tick.
// RULE2: internal consumers see a state change one further scan tick later.
// RULE3: relay outputs follow one more scan tick later, three ticks at most overall.
// RULE4: per-channel polarity, normally open by default, sets energized reading 1 or 0.
// RULE5: activation threshold, default 88 V, 0.1 V steps; above it energizes.
// RULE6: release threshold, default 60 V; below it de-energizes.
// RULE7: rising reported state is delayed by per-channel activation delay, ms steps.
// RULE8: falling reported state is delayed by per-channel drop-off time, ms steps.
// RULE9: AC mode adds 30 ms drop-off and releases at a tenth of activation threshold.
// RULE10: 32-bit counter per channel counts reported 0 to 1 transitions, resets to zero.
// RULE11: a clear command for a channel zeroes its transition counter.
// RULE12: eight independent channels, each with its own settings and counter.
// RULE13: between release and activation thresholds the previous raw state holds.
// RULE14: delays count scan ticks; state changes only after raw state stays stable.
`ifndef DIC_CONSTS_SVH
`define DIC_CONSTS_SVH

`define DIC_NUM_CH 8
`define DIC_CLK_MHZ 25
`define DIC_SCAN_PERIOD_US 5000
`define DIC_SCAN_CYCLES (`DIC_SCAN_PERIOD_US * `DIC_CLK_MHZ)
`define DIC_SCAN_MS 5
`define DIC_AC_EXTRA_MS 30

// thresholds are held in 0.1 V units
`define DIC_ACT_THR_RST 12'h370
`define DIC_REL_THR_RST 12'h258
`define DIC_ACT_THR_MIN 12'h0a0
`define DIC_REL_THR_MIN 12'h064
`define DIC_THR_MAX 12'h7d0
`define DIC_DLY_MAX 22'h1b7740
`define DIC_AC_DIVISOR 12'h00a

// channel window: base = channel * 0x20
`define DIC_CH_STRIDE_SHIFT 5
`define DIC_OFF_CFG 3'h0
`define DIC_OFF_ACT_THR 3'h1
`define DIC_OFF_REL_THR 3'h2
`define DIC_OFF_ACT_DLY 3'h3
`define DIC_OFF_DROP_DLY 3'h4
`define DIC_OFF_COUNT 3'h5
`define DIC_ADDR_STATUS 12'h100
`define DIC_ADDR_CLEAR 12'h104

`define DIC_CFG_NC_BIT 0
`define DIC_CFG_AC_BIT 1
`define DIC_STAT_QUAL_LSB 0
`define DIC_STAT_LOGIC_LSB 8
`define DIC_STAT_RELAY_LSB 16

`define DIC_RESP_OKAY 2'h0
`define DIC_RESP_SLVERR 2'h2

`endif

// ===== hdl/dic_digital_input_conditioner.sv
`include "dic_consts.svh"

module dic_digital_input_conditioner import dic_pkg::*; #(
   parameter int unsigned NUM_CH = `DIC_NUM_CH,
   parameter int unsigned SCAN_CYCLES = `DIC_SCAN_CYCLES
) (
   input wire logic CLOCK_IN,
   input wire logic ARST_N_IN,
   input wire logic [NUM_CH*12-1:0] VOLT_IN,
   input wire logic [11:0] AXI_AWADDR_IN,
   input wire logic AXI_AWVALID_IN,
   output logic AXI_AWREADY_OUT,
   input wire logic [31:0] AXI_WDATA_IN,
   input wire logic [3:0] AXI_WSTRB_IN,
   input wire logic AXI_WVALID_IN,
   output logic AXI_WREADY_OUT,
   output logic [1:0] AXI_BRESP_OUT,
   output logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic [11:0] AXI_ARADDR_IN,
   input wire logic AXI_ARVALID_IN,
   output logic AXI_ARREADY_OUT,
   output logic [31:0] AXI_RDATA_OUT,
   output logic [1:0] AXI_RRESP_OUT,
   output logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   output logic [NUM_CH-1:0] STATE_OUT,
   output logic [NUM_CH-1:0] LOGIC_STATE_OUT,
   output logic [NUM_CH-1:0] RELAY_OUT
);
   typedef struct packed {
      logic aw_got;
      logic w_got;
      dic_addr_t awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [NUM_CH-1:0] nc;
      logic [NUM_CH-1:0] ac;
      dic_volt_t [NUM_CH-1:0] act_thr;
      dic_volt_t [NUM_CH-1:0] rel_thr;
      dic_dly_t [NUM_CH-1:0] act_dly;
      dic_dly_t [NUM_CH-1:0] drop_dly;
      logic [NUM_CH-1:0] clr;
      logic [NUM_CH-1:0] logic_st;
      logic [NUM_CH-1:0] relay;
   } dic_top_st_t;

   localparam dic_top_st_t ST_RST = '{
      act_thr: {NUM_CH{`DIC_ACT_THR_RST}},
      rel_thr: {NUM_CH{`DIC_REL_THR_RST}},
      default: '0
   };

   dic_top_st_t st_ff;
   dic_top_st_t nxt_st;
   logic tick;
   logic [NUM_CH-1:0] qual;
   dic_cnt_t [NUM_CH-1:0] count;

   ////////////////////////////////////////////////////////////////////////
   // register map, one aligned 32-bit word per register
   // channel c owns the window at c * 0x20:
   //   +0x00 bit 0 normally closed, bit 1 alternating supply mode
   //   +0x04 activation threshold, +0x08 release threshold, 0.1 V units
   //   +0x0c activation delay, +0x10 drop-off delay, in ms
   //   +0x14 rising transition count, read only
   // 0x100 status, read only: qualified, internal and relay bytes
   // 0x104 transition count clear: a one in bit c zeroes counter c
   // writes to read-only words are accepted and dropped
   // unmapped words answer with an error and change nothing

   ////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // settings outside the allowed range are pulled to its nearest end
   function automatic dic_volt_t clamp_thr(input logic [31:0] v,
                                           input dic_volt_t lo);
      dic_volt_t res;
      if (v > 32'(`DIC_THR_MAX)) begin
         res = `DIC_THR_MAX;
      end else if (v < 32'(lo)) begin
         res = lo;
      end else begin
         res = v[11:0];
      end
      return res;
   endfunction

   function automatic dic_dly_t clamp_dly(input logic [31:0] v);
      dic_dly_t res;
      if (v > 32'(`DIC_DLY_MAX)) begin
         res = `DIC_DLY_MAX;
      end else begin
         res = v[21:0];
      end
      return res;
   endfunction

   // the three consumer stages side by side, one byte each
   function automatic logic [31:0] pack_status(input logic [NUM_CH-1:0] q,
                                               input logic [NUM_CH-1:0] l,
                                               input logic [NUM_CH-1:0] r);
      logic [31:0] res;
      res = '0;
      res[`DIC_STAT_QUAL_LSB +: NUM_CH] = q;
      res[`DIC_STAT_LOGIC_LSB +: NUM_CH] = l;
      res[`DIC_STAT_RELAY_LSB +: NUM_CH] = r;
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // scan timing and channels

   dic_scan_tick #(
      .CYCLES(SCAN_CYCLES)
   ) u_tick (
      .clk_in(CLOCK_IN),
      .arst_n_in(ARST_N_IN),
      .tick_out(tick)
   );

   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch // see RULE12
      dic_channel u_ch (
         .clk_in(CLOCK_IN),
         .arst_n_in(ARST_N_IN),
         .tick_in(tick),
         .volt_in(VOLT_IN[c*12 +: 12]),
         .act_thr_in(st_ff.act_thr[c]),
         .rel_thr_in(st_ff.rel_thr[c]),
         .normally_closed_in(st_ff.nc[c]),
         .ac_mode_in(st_ff.ac[c]),
         .act_dly_in(st_ff.act_dly[c]),
         .drop_dly_in(st_ff.drop_dly[c]),
         .clear_in(st_ff.clr[c]),
         .state_out(qual[c]),
         .count_out(count[c])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      logic [31:0] m;
      logic [2:0] ch;
      logic [2:0] off;
      logic hit;
      m = '0;
      ch = '0;
      off = '0;
      hit = 1'b0;
      nxt_st = st_ff;
      nxt_st.clr = '0;

      // one scan round per consumer stage
      if (tick) begin
         nxt_st.logic_st = qual; // see RULE2
         nxt_st.relay = st_ff.logic_st; // see RULE3
      end

      // write address and data are taken in either order
      if (AXI_AWVALID_IN && AXI_AWREADY_OUT) begin
         nxt_st.aw_got = 1'b1;
         nxt_st.awaddr = AXI_AWADDR_IN;
      end
      if (AXI_WVALID_IN && AXI_WREADY_OUT) begin
         nxt_st.w_got = 1'b1;
         nxt_st.wdata = AXI_WDATA_IN;
         nxt_st.wstrb = AXI_WSTRB_IN;
      end
      if (st_ff.bvalid && AXI_BREADY_IN) begin
         nxt_st.bvalid = 1'b0;
      end

      if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = `DIC_RESP_OKAY;
         ch = st_ff.awaddr[7:5];
         off = st_ff.awaddr[4:2];
         if (st_ff.awaddr[11:8] == 4'h0 && 32'(ch) < NUM_CH) begin
            if (off == `DIC_OFF_CFG) begin
               m = merge_bytes({30'h0, st_ff.ac[ch], st_ff.nc[ch]},
                               st_ff.wdata, st_ff.wstrb);
               nxt_st.nc[ch] = m[`DIC_CFG_NC_BIT]; // see RULE4
               nxt_st.ac[ch] = m[`DIC_CFG_AC_BIT]; // see RULE9
            end else if (off == `DIC_OFF_ACT_THR) begin
               m = merge_bytes({20'h0, st_ff.act_thr[ch]},
                               st_ff.wdata, st_ff.wstrb);
               nxt_st.act_thr[ch] = clamp_thr(m, `DIC_ACT_THR_MIN); // see RULE5
            end else if (off == `DIC_OFF_REL_THR) begin
               m = merge_bytes({20'h0, st_ff.rel_thr[ch]},
                               st_ff.wdata, st_ff.wstrb);
               nxt_st.rel_thr[ch] = clamp_thr(m, `DIC_REL_THR_MIN); // see RULE6
            end else if (off == `DIC_OFF_ACT_DLY) begin
               m = merge_bytes({10'h0, st_ff.act_dly[ch]},
                               st_ff.wdata, st_ff.wstrb);
               nxt_st.act_dly[ch] = clamp_dly(m); // see RULE7
            end else if (off == `DIC_OFF_DROP_DLY) begin
               m = merge_bytes({10'h0, st_ff.drop_dly[ch]},
                               st_ff.wdata, st_ff.wstrb);
               nxt_st.drop_dly[ch] = clamp_dly(m); // see RULE8
            end else if (off == `DIC_OFF_COUNT) begin
               // counter is read-only, the write is dropped
               hit = 1'b1;
            end else begin
               nxt_st.bresp = `DIC_RESP_SLVERR;
            end
         end else if (st_ff.awaddr == `DIC_ADDR_CLEAR) begin
            // one-cycle pulse per written one bit
            if (st_ff.wstrb[0]) begin
               nxt_st.clr = st_ff.wdata[NUM_CH-1:0]; // see RULE11
            end
         end else if (st_ff.awaddr == `DIC_ADDR_STATUS) begin
            hit = 1'b1;
         end else begin
            nxt_st.bresp = `DIC_RESP_SLVERR;
         end
      end

      if (st_ff.rvalid && AXI_RREADY_IN) begin
         nxt_st.rvalid = 1'b0;
      end
      if (AXI_ARVALID_IN && AXI_ARREADY_OUT) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = `DIC_RESP_OKAY;
         nxt_st.rdata = '0;
         ch = AXI_ARADDR_IN[7:5];
         off = AXI_ARADDR_IN[4:2];
         if (AXI_ARADDR_IN[11:8] == 4'h0 && 32'(ch) < NUM_CH) begin
            if (off == `DIC_OFF_CFG) begin
               nxt_st.rdata = {30'h0, st_ff.ac[ch], st_ff.nc[ch]};
            end else if (off == `DIC_OFF_ACT_THR) begin
               nxt_st.rdata = {20'h0, st_ff.act_thr[ch]};
            end else if (off == `DIC_OFF_REL_THR) begin
               nxt_st.rdata = {20'h0, st_ff.rel_thr[ch]};
            end else if (off == `DIC_OFF_ACT_DLY) begin
               nxt_st.rdata = {10'h0, st_ff.act_dly[ch]};
            end else if (off == `DIC_OFF_DROP_DLY) begin
               nxt_st.rdata = {10'h0, st_ff.drop_dly[ch]};
            end else if (off == `DIC_OFF_COUNT) begin
               nxt_st.rdata = count[ch]; // see RULE10
            end else begin
               nxt_st.rresp = `DIC_RESP_SLVERR;
            end
         end else if (AXI_ARADDR_IN == `DIC_ADDR_STATUS) begin
            nxt_st.rdata = pack_status(qual, st_ff.logic_st, st_ff.relay);
         end else if (AXI_ARADDR_IN == `DIC_ADDR_CLEAR) begin
            nxt_st.rdata = '0;
         end else begin
            nxt_st.rresp = `DIC_RESP_SLVERR;
         end
      end
      if (hit) begin
         nxt_st.bresp = `DIC_RESP_OKAY;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register and outputs

   always_ff @(posedge CLOCK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // one write and one read in flight keeps the slave trivially ordered
   assign AXI_AWREADY_OUT = !st_ff.aw_got && !st_ff.bvalid;
   assign AXI_WREADY_OUT = !st_ff.w_got && !st_ff.bvalid;
   assign AXI_BVALID_OUT = st_ff.bvalid;
   assign AXI_BRESP_OUT = st_ff.bresp;
   assign AXI_ARREADY_OUT = !st_ff.rvalid;
   assign AXI_RVALID_OUT = st_ff.rvalid;
   assign AXI_RDATA_OUT = st_ff.rdata;
   assign AXI_RRESP_OUT = st_ff.rresp;

   assign STATE_OUT = qual;
   assign LOGIC_STATE_OUT = st_ff.logic_st;
   assign RELAY_OUT = st_ff.relay;
endmodule

// ===== hdl/dic_pkg.sv
package dic_pkg;
   typedef logic [11:0] dic_volt_t;
   typedef logic [21:0] dic_dly_t;
   typedef logic [31:0] dic_cnt_t;
   typedef logic [11:0] dic_addr_t;
endpackage

// ===== hdl/dic_scan_tick.sv
`include "dic_consts.svh"

module dic_scan_tick import dic_pkg::*; #(
   parameter int unsigned CYCLES = `DIC_SCAN_CYCLES
) (
   input wire logic clk_in,
   input wire logic arst_n_in,
   output logic tick_out
);
   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } dic_tick_st_t;

   dic_tick_st_t st_ff;
   dic_tick_st_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (st_ff.cnt >= CYCLES - 1) begin
         nxt_st.cnt = '0;
         nxt_st.tick = 1'b1; // see RULE1
      end else begin
         nxt_st.cnt = st_ff.cnt + 32'h1;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick_out = st_ff.tick;
endmodule

// ===== tb/dic_digital_input_conditioner_asserts.sv
module dic_digital_input_conditioner_asserts import dic_pkg::*; #(
   parameter int unsigned NUM_CH = 8
) (
   input wire logic CLOCK_IN,
   input wire logic ARST_N_IN,
   input wire logic AXI_AWVALID_IN,
   input wire logic AXI_AWREADY_OUT,
   input wire logic AXI_WVALID_IN,
   input wire logic AXI_WREADY_OUT,
   input wire logic [1:0] AXI_BRESP_OUT,
   input wire logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic AXI_ARVALID_IN,
   input wire logic AXI_ARREADY_OUT,
   input wire logic [31:0] AXI_RDATA_OUT,
   input wire logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   input wire logic [NUM_CH-1:0] STATE_OUT,
   input wire logic [NUM_CH-1:0] LOGIC_STATE_OUT,
   input wire logic [NUM_CH-1:0] RELAY_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!ARST_N_IN);
   ////////////////////////////////////////////////////////////////////////////
   sequence both_taken;
      AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT;
   endsequence
   sequence resp_late;
      !AXI_BVALID_OUT ##1 AXI_BVALID_OUT;
   endsequence
   wr_resp_time_a: assert property (both_taken |=> resp_late)
      else $error("write response not two cycles after handshake");
   b_hold_a: assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=>
      AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
      else $error("write response dropped before acceptance");
   r_hold_a: assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=>
      AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
      else $error("read data dropped before acceptance");
   rd_answer_a: assert property (AXI_ARVALID_IN && AXI_ARREADY_OUT |=>
      AXI_RVALID_OUT)
      else $error("read data not one cycle after address");
   ar_block_a: assert property (AXI_RVALID_OUT |-> !AXI_ARREADY_OUT)
      else $error("read address accepted while data pending");
   ////////////////////////////////////////////////////////////////////////////
   // state moves only on scan ticks, which are far apart
   state_spacing_a: assert property (
      $changed(STATE_OUT) |=> $stable(STATE_OUT)[*8])
      else $error("channel state changed between scan ticks");
   logic_follow_a: assert property (
      $changed(LOGIC_STATE_OUT) |-> LOGIC_STATE_OUT == $past(STATE_OUT))
      else $error("internal state is not the previous channel state");
   relay_follow_a: assert property (
      $changed(RELAY_OUT) |-> RELAY_OUT == $past(LOGIC_STATE_OUT))
      else $error("relay drive is not the previous internal state");
endmodule

bind dic_digital_input_conditioner dic_digital_input_conditioner_asserts #(
   .NUM_CH(NUM_CH)) i_asserts (.CLOCK_IN(CLOCK_IN), .ARST_N_IN(ARST_N_IN),
   .AXI_AWVALID_IN(AXI_AWVALID_IN), .AXI_AWREADY_OUT(AXI_AWREADY_OUT),
   .AXI_WVALID_IN(AXI_WVALID_IN), .AXI_WREADY_OUT(AXI_WREADY_OUT),
   .AXI_BRESP_OUT(AXI_BRESP_OUT), .AXI_BVALID_OUT(AXI_BVALID_OUT),
   .AXI_BREADY_IN(AXI_BREADY_IN), .AXI_ARVALID_IN(AXI_ARVALID_IN),
   .AXI_ARREADY_OUT(AXI_ARREADY_OUT), .AXI_RDATA_OUT(AXI_RDATA_OUT),
   .AXI_RVALID_OUT(AXI_RVALID_OUT), .AXI_RREADY_IN(AXI_RREADY_IN),
   .STATE_OUT(STATE_OUT), .LOGIC_STATE_OUT(LOGIC_STATE_OUT),
   .RELAY_OUT(RELAY_OUT));

// ===== tb/dic_digital_input_conditioner_bench.sv
module dic_digital_input_conditioner_bench import dic_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int SC = 20;
   logic clk = 1'h0;
   logic arst_n = 1'h0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] rdata, d;
   logic [7:0] st, lg, rl;
   logic [95:0] volt;
   logic [31:0] dflt [6] = '{32'h0, 32'h370, 32'h258, 32'h0, 32'h0, 32'h0};
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   dic_field_wiring #(.NUM_CH(8)) i_wiring (.clk_in(clk), .volt_out(volt));
   dic_digital_input_conditioner #(.NUM_CH(8), .SCAN_CYCLES(SC)) i_dut (
      .CLOCK_IN(clk), .ARST_N_IN(arst_n), .VOLT_IN(volt),
      .AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid),
      .AXI_AWREADY_OUT(awready), .AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(4'hf),
      .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready), .AXI_BRESP_OUT(bresp),
      .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
      .AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid),
      .AXI_ARREADY_OUT(arready), .AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp),
      .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready), .STATE_OUT(st),
      .LOGIC_STATE_OUT(lg), .RELAY_OUT(rl));
   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // bready and rready come late on purpose so responses must stand
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      @(posedge clk);
      while (!(bvalid === 1'h1 && bready === 1'h1)) begin
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) bready <= 1'h1;
         @(posedge clk);
      end
      r = bresp;
      bready <= 1'h0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      @(posedge clk);
      while (!(rvalid === 1'h1 && rready === 1'h1)) begin
         if (arready) arvalid <= 1'h0;
         if (rvalid) rready <= 1'h1;
         @(posedge clk);
      end
      d = rdata;
      r = rresp;
      rready <= 1'h0;
   endtask
   // q extra ticks of programmed delay shift the zero-to-one tick window
   task edge_time(input int ch, input logic v, input int q);
      int n;
      n = 0;
      while (st[ch] !== v && n < 400) begin
         @(posedge clk);
         n++;
      end
      check(32'(n >= SC * q && n <= SC * (1 + q) + 3), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(posedge clk);
      arst_n <= 1'h1;
      for (int i = 0; i < 6; i++) begin
         rd(12'(i * 4));
         check(d, dflt[i]);
      end
      rd(12'h0e4);
      check(d, 32'h370);
      rd(12'h018);
      check(32'(r), 32'h2);
      i_wiring.set_volt(0, 12'h3e8);
      edge_time(0, 1'h1, 0);
      check(32'(lg), 32'h0);
      check(32'(st), 32'h1);
      repeat (2 * SC + 2) @(posedge clk);
      rd(12'h100);
      check(d, 32'h00010101);
      check(32'(lg), 32'h1);
      check(32'(rl), 32'h1);
      rd(12'h014);
      check(d, 32'h1);
      i_wiring.set_volt(0, 12'h2bc);
      repeat (3 * SC) @(posedge clk);
      check(32'(st[0]), 32'h1);
      i_wiring.set_volt(0, 12'h1f4);
      edge_time(0, 1'h0, 0);
      wr(12'h014, 32'h5);
      check(32'(r), 32'h0);
      wr(12'h104, 32'h1);
      rd(12'h014);
      check(d, 32'h0);
      wr(12'h020, 32'h1);
      edge_time(1, 1'h1, 0);
      i_wiring.set_volt(1, 12'h3e8);
      edge_time(1, 1'h0, 0);
      wr(12'h04c, 32'd20);
      wr(12'h050, 32'd12);
      i_wiring.set_volt(2, 12'h3e8);
      edge_time(2, 1'h1, 4);
      i_wiring.set_volt(2, 12'h0);
      edge_time(2, 1'h0, 3);
      wr(12'h060, 32'h2);
      i_wiring.set_volt(3, 12'h3e8);
      edge_time(3, 1'h1, 0);
      i_wiring.set_volt(3, 12'h1f4);
      repeat (8 * SC) @(posedge clk);
      check(32'(st[3]), 32'h1);
      i_wiring.set_volt(3, 12'h032);
      edge_time(3, 1'h0, 6);
      test_done();
   end
endmodule

// ===== tb/dic_field_wiring.sv
module dic_field_wiring import dic_pkg::*; #(
   parameter int unsigned NUM_CH = 8
) (
   input wire logic clk_in,
   output logic [NUM_CH*12-1:0] volt_out
);
   timeunit 1ns;
   timeprecision 1ns;
   initial volt_out = '0;
   // measured voltage is a level held until the wiring changes it
   task automatic set_volt(input int ch, input dic_volt_t v);
      @(posedge clk_in);
      volt_out[ch*12+:12] <= v;
   endtask
endmodule
